// ===== core/cct_pkg.sv
// types shared by the capture/compare timer and its bench
// assumes the offsets and fields of cct_regs.svh
package cct_pkg;
    // clock select codes
    typedef enum logic [1:0] {
        CCT_DIV2 = 2'b00,
        CCT_DIV4 = 2'b01,
        CCT_DIV8 = 2'b10,
        CCT_EXT  = 2'b11
    } cct_clk_sel_t;

    // axi4-lite, master to slave
    typedef struct packed {
        logic        awvalid;
        logic [7:0]  awaddr;
        logic        wvalid;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bready;
        logic        arvalid;
        logic [7:0]  araddr;
        logic        rready;
    } cct_axi_req_t;

    // axi4-lite, slave to master
    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } cct_axi_rsp_t;
endpackage : cct_pkg

// ===== core/cct_regs.svh
// register offsets, field positions, reset values for the capture/compare timer
// assumes a 32-bit axi4-lite slave, one byte register per aligned word
`ifndef CCT_REGS_SVH
`define CCT_REGS_SVH
`define CCT_OFS_CTL1   8'h00
`define CCT_OFS_CTL2   8'h04
`define CCT_OFS_STAT   8'h08
`define CCT_OFS_CAP1H  8'h0c
`define CCT_OFS_CAP1L  8'h10
`define CCT_OFS_CMP1H  8'h14
`define CCT_OFS_CMP1L  8'h18
`define CCT_OFS_CAP2H  8'h1c
`define CCT_OFS_CAP2L  8'h20
`define CCT_OFS_CMP2H  8'h24
`define CCT_OFS_CMP2L  8'h28
`define CCT_OFS_CNTH   8'h2c
`define CCT_OFS_CNTL   8'h30
`define CCT_OFS_SCNTH  8'h34
`define CCT_OFS_SCNTL  8'h38
// control one fields
`define CCT_C1_LVL1    0
`define CCT_C1_LVL2    1
`define CCT_C1_EDGE1   2
`define CCT_C1_FORCE1  3
`define CCT_C1_FORCE2  4
`define CCT_C1_OVFIE   5
`define CCT_C1_CMPIE   6
`define CCT_C1_CAPIE   7
// control two fields
`define CCT_C2_OE1     0
`define CCT_C2_OE2     1
`define CCT_C2_CS_LO   2
`define CCT_C2_CS_HI   3
`define CCT_C2_EXEDGE  4
`define CCT_C2_EDGE2   5
`define CCT_C2_OPM     6
`define CCT_C2_PWM     7
// status fields
`define CCT_ST_CAP1    0
`define CCT_ST_CAP2    1
`define CCT_ST_CMP1    2
`define CCT_ST_CMP2    3
`define CCT_ST_OVF     4
// reset values
`define CCT_CNT_RST    16'hfffc
`define CCT_CMP_RST    16'h8000
`define CCT_CTL_RST    8'h00
`endif

// ===== core/cct_timer.sv
// capture/compare timer: 16-bit counter, two captures, two compares
// assumes one 50 mhz clock, synchronous reset, axi4-lite register access
`timescale 1ns/1ps
`default_nettype none
`include "cct_regs.svh"

module cct_timer
    import cct_pkg::*;
(
    input  wire logic         clk,
    input  wire logic         reset,
    input  wire cct_axi_req_t axi_req,
    output var  cct_axi_rsp_t axi_rsp,
    input  wire logic         cpu_irq_mask,
    input  wire logic         halt,
    input  wire logic         ext_clock_pin,
    input  wire logic [1:0]   capture_pin,
    output logic [1:0]        compare_output_pin,
    output logic [1:0]        compare_output_pin_oe,
    output logic              timer_irq
);

    // ****************************************************************
    // state
    // ****************************************************************
    typedef struct packed {
        logic             aw_ok;
        logic [7:0]       aw_addr;
        logic             w_ok;
        logic [7:0]       w_data;
        logic             w_en;
        logic             bvalid;
        logic [1:0]       bresp;
        logic             rvalid;
        logic [7:0]       rdata;
        logic [1:0]       rresp;
        logic [7:0]       ctl1;
        logic [7:0]       ctl2;
        logic [15:0]      cnt;
        logic [2:0]       pre;
        logic [2:0]       ext_s;
        logic [1:0][2:0]  cap_s;
        logic [1:0][15:0] cap;
        logic [1:0][15:0] cmp;
        logic [1:0]       cap_block;
        logic [1:0]       cmp_hold;
        logic [1:0]       cap_f;
        logic [1:0]       cmp_f;
        logic             ovf_f;
        logic [1:0]       arm_cap;
        logic [1:0]       arm_cmp;
        logic             arm_ovf;
        logic [7:0]       lo_latch;
        logic             latched;
        logic [1:0]       pin;
    } cct_state_t;

    cct_state_t s_q;
    cct_state_t s_d;

    // ****************************************************************
    // bus answers
    // ****************************************************************
    // one write and one read in flight; ready drops while answer pends
    always_comb begin
        axi_rsp.awready = !s_q.aw_ok && !s_q.bvalid;
        axi_rsp.wready  = !s_q.w_ok && !s_q.bvalid;
        axi_rsp.bvalid  = s_q.bvalid;
        axi_rsp.bresp   = s_q.bresp;
        axi_rsp.arready = !s_q.rvalid;
        axi_rsp.rvalid  = s_q.rvalid;
        axi_rsp.rdata   = {24'h000000, s_q.rdata};
        axi_rsp.rresp   = s_q.rresp;
    end

    // pins and interrupt
    assign compare_output_pin    = s_q.pin;
    assign compare_output_pin_oe = {s_q.ctl2[`CCT_C2_OE2], s_q.ctl2[`CCT_C2_OE1]};

    // request stays pending while masked, fires once mask clears
    assign timer_irq = !cpu_irq_mask && (
        (s_q.ovf_f && s_q.ctl1[`CCT_C1_OVFIE]) ||
        ((|s_q.cap_f) && s_q.ctl1[`CCT_C1_CAPIE]) ||
        ((|s_q.cmp_f) && s_q.ctl1[`CCT_C1_CMPIE]));

    // ****************************************************************
    // next state
    // ****************************************************************
    always_comb begin
        logic         rd;
        logic         wr;
        logic [7:0]   ra;
        logic [7:0]   wa;
        logic         tick;
        logic         ext_edge;
        logic [15:0]  cnt_inc;
        logic [1:0]   cs;
        logic [1:0]   edge_sel;
        logic [1:0]   lvl;
        logic [1:0]   cap_ev;
        logic [1:0]   cmp_ev;
        logic [1:0]   cap_lo_acc;
        logic [1:0]   cmp_lo_acc;
        logic         cnt_lo_acc;
        logic         stat_rd;
        logic         ovf_ev;
        logic         modes_off;
        rd         = axi_req.arvalid && !s_q.rvalid;
        wr         = s_q.aw_ok && s_q.w_ok && !s_q.bvalid;
        ra         = axi_req.araddr & 8'hfc;
        wa         = s_q.aw_addr & 8'hfc;
        cs         = s_q.ctl2[`CCT_C2_CS_HI:`CCT_C2_CS_LO];
        edge_sel   = {s_q.ctl2[`CCT_C2_EDGE2], s_q.ctl1[`CCT_C1_EDGE1]};
        lvl        = {s_q.ctl1[`CCT_C1_LVL2], s_q.ctl1[`CCT_C1_LVL1]};
        modes_off  = s_q.ctl2[`CCT_C2_OPM] || s_q.ctl2[`CCT_C2_PWM];
        cnt_inc    = s_q.cnt + 16'h0001;
        cap_ev     = 2'b00;
        cmp_ev     = 2'b00;
        cap_lo_acc = 2'b00;
        cmp_lo_acc = 2'b00;
        cnt_lo_acc = 1'b0;
        stat_rd    = 1'b0;
        // defaults first so no path leaves a temporary unset
        tick       = 1'b0;
        ext_edge   = 1'b0;
        ovf_ev     = 1'b0;
        s_d        = s_q;

        // synchronisers: first stage feeds only the second
        s_d.ext_s = {s_q.ext_s[1:0], ext_clock_pin};
        for (int i = 0; i < 2; i++) begin
            s_d.cap_s[i] = {s_q.cap_s[i][1:0], capture_pin[i]};
        end

        // timer clock from prescaler or external pin edge
        s_d.pre  = s_q.pre + 3'd1;
        ext_edge = s_q.ctl2[`CCT_C2_EXEDGE] ? (s_q.ext_s[1] && !s_q.ext_s[2])
                                            : (!s_q.ext_s[1] && s_q.ext_s[2]);
        case (cct_clk_sel_t'(cs))
            CCT_DIV2: tick = s_q.pre[0];
            CCT_DIV4: tick = &s_q.pre[1:0];
            CCT_DIV8: tick = &s_q.pre;
            CCT_EXT:  tick = ext_edge;
            default:  tick = 1'b0;
        endcase
        tick = tick && !halt;

        // ------------------------------------------------------------
        // counter and overflow
        // ------------------------------------------------------------
        ovf_ev = tick && (s_q.cnt == 16'hffff);
        if (tick) begin
            s_d.cnt = cnt_inc;
        end

        // compare each timer clock; div-by-2 hits at the value itself,
        // slower clocks hit as the counter leaves it
        for (int i = 0; i < 2; i++) begin
            if (tick && !s_q.cmp_hold[i]) begin
                if (cct_clk_sel_t'(cs) == CCT_DIV2) begin
                    cmp_ev[i] = (cnt_inc == s_q.cmp[i]);
                end else begin
                    cmp_ev[i] = (s_q.cnt == s_q.cmp[i]);
                end
            end
            // only an enabled pin shows the programmed level
            if (cmp_ev[i] && s_q.ctl2[`CCT_C2_OE1 + i]) begin
                s_d.pin[i] = lvl[i];
            end
        end

        // capture on the synchronised active edge; sync plus edge plus
        // flag register gives the flag 3 clocks after the pin moves
        for (int i = 0; i < 2; i++) begin
            if (edge_sel[i]) begin
                cap_ev[i] = s_q.cap_s[i][1] && !s_q.cap_s[i][2];
            end else begin
                cap_ev[i] = !s_q.cap_s[i][1] && s_q.cap_s[i][2];
            end
            cap_ev[i] = cap_ev[i] && !s_q.cap_block[i];
            if (cap_ev[i]) begin
                s_d.cap[i] = s_q.cnt;
            end
        end

        // ------------------------------------------------------------
        // register reads, with their side effects
        // ------------------------------------------------------------
        if (rd) begin
            s_d.rvalid = 1'b1;
            s_d.rresp  = 2'b00;
            s_d.rdata  = 8'h00;
            case (ra)
                `CCT_OFS_CTL1: s_d.rdata = s_q.ctl1;
                `CCT_OFS_CTL2: s_d.rdata = s_q.ctl2;
                `CCT_OFS_STAT: begin
                    s_d.rdata = {3'b000, s_q.ovf_f, s_q.cmp_f, s_q.cap_f};
                    stat_rd   = 1'b1;
                end
                `CCT_OFS_CAP1H: begin
                    s_d.rdata        = s_q.cap[0][15:8];
                    s_d.cap_block[0] = 1'b1;
                end
                `CCT_OFS_CAP1L: begin
                    s_d.rdata     = s_q.cap[0][7:0];
                    cap_lo_acc[0] = 1'b1;
                end
                `CCT_OFS_CAP2H: begin
                    s_d.rdata        = s_q.cap[1][15:8];
                    s_d.cap_block[1] = 1'b1;
                end
                `CCT_OFS_CAP2L: begin
                    s_d.rdata     = s_q.cap[1][7:0];
                    cap_lo_acc[1] = 1'b1;
                end
                `CCT_OFS_CMP1H: s_d.rdata = s_q.cmp[0][15:8];
                `CCT_OFS_CMP1L: begin
                    s_d.rdata     = s_q.cmp[0][7:0];
                    cmp_lo_acc[0] = 1'b1;
                end
                `CCT_OFS_CMP2H: s_d.rdata = s_q.cmp[1][15:8];
                `CCT_OFS_CMP2L: begin
                    s_d.rdata     = s_q.cmp[1][7:0];
                    cmp_lo_acc[1] = 1'b1;
                end
                `CCT_OFS_CNTH, `CCT_OFS_SCNTH: begin
                    s_d.rdata = s_q.cnt[15:8];
                    // repeated high reads keep the first snapshot
                    if (!s_q.latched) begin
                        s_d.lo_latch = s_q.cnt[7:0];
                        s_d.latched  = 1'b1;
                    end
                end
                `CCT_OFS_CNTL, `CCT_OFS_SCNTL: begin
                    s_d.rdata   = s_q.latched ? s_q.lo_latch : s_q.cnt[7:0];
                    s_d.latched = 1'b0;
                    cnt_lo_acc  = (ra == `CCT_OFS_CNTL);
                end
                default: s_d.rresp = 2'b10;
            endcase
        end else if (s_q.rvalid && axi_req.rready) begin
            s_d.rvalid = 1'b0;
        end

        // ------------------------------------------------------------
        // write channel capture, either order
        // ------------------------------------------------------------
        // aw and w may arrive apart; each is held until the write completes
        if (axi_req.awvalid && axi_rsp.awready) begin
            s_d.aw_ok   = 1'b1;
            s_d.aw_addr = axi_req.awaddr;
        end
        if (axi_req.wvalid && axi_rsp.wready) begin
            s_d.w_ok   = 1'b1;
            s_d.w_data = axi_req.wdata[7:0];
            s_d.w_en   = axi_req.wstrb[0];
        end
        if (s_q.bvalid && axi_req.bready) begin
            s_d.bvalid = 1'b0;
        end

        // ------------------------------------------------------------
        // register writes; a cleared byte lane leaves registers alone
        // ------------------------------------------------------------
        if (wr) begin
            s_d.aw_ok  = 1'b0;
            s_d.w_ok   = 1'b0;
            s_d.bvalid = 1'b1;
            s_d.bresp  = 2'b00;
            case (wa)
                `CCT_OFS_CTL1: if (s_q.w_en) begin
                    // force bits act once and are not stored
                    s_d.ctl1 = s_q.w_data & 8'he7;
                    for (int i = 0; i < 2; i++) begin
                        if (s_q.w_data[`CCT_C1_FORCE1 + i] && !modes_off &&
                            s_q.ctl2[`CCT_C2_OE1 + i]) begin
                            s_d.pin[i] = s_q.w_data[`CCT_C1_LVL1 + i];
                        end
                    end
                end
                `CCT_OFS_CTL2: if (s_q.w_en) begin
                    s_d.ctl2 = s_q.w_data;
                end
                `CCT_OFS_STAT: ;
                `CCT_OFS_CAP1H, `CCT_OFS_CAP2H: ;
                // a clear step needs the byte lane, like every other write
                `CCT_OFS_CAP1L: cap_lo_acc[0] = s_q.w_en;
                `CCT_OFS_CAP2L: cap_lo_acc[1] = s_q.w_en;
                `CCT_OFS_CMP1H: if (s_q.w_en) begin
                    s_d.cmp[0][15:8] = s_q.w_data;
                    s_d.cmp_hold[0]  = 1'b1;
                end
                `CCT_OFS_CMP2H: if (s_q.w_en) begin
                    s_d.cmp[1][15:8] = s_q.w_data;
                    s_d.cmp_hold[1]  = 1'b1;
                end
                `CCT_OFS_CMP1L: if (s_q.w_en) begin
                    s_d.cmp[0][7:0] = s_q.w_data;
                    s_d.cmp_hold[0] = 1'b0;
                    cmp_lo_acc[0]   = 1'b1;
                end
                `CCT_OFS_CMP2L: if (s_q.w_en) begin
                    s_d.cmp[1][7:0] = s_q.w_data;
                    s_d.cmp_hold[1] = 1'b0;
                    cmp_lo_acc[1]   = 1'b1;
                end
                `CCT_OFS_CNTH, `CCT_OFS_SCNTH: ;
                `CCT_OFS_CNTL, `CCT_OFS_SCNTL: if (s_q.w_en) begin
                    // reload wins over a timer clock in the same cycle
                    s_d.cnt    = `CCT_CNT_RST;
                    cnt_lo_acc = cnt_lo_acc || (wa == `CCT_OFS_CNTL);
                end
                default: s_d.bresp = 2'b10;
            endcase
        end

        // ------------------------------------------------------------
        // flags: two-step clear, a new event beats the clear
        // ------------------------------------------------------------
        if (stat_rd) begin
            s_d.arm_ovf = s_q.arm_ovf || s_q.ovf_f;
            s_d.arm_cap = s_q.arm_cap | s_q.cap_f;
            s_d.arm_cmp = s_q.arm_cmp | s_q.cmp_f;
        end
        if (cnt_lo_acc) begin
            if (s_q.arm_ovf) begin
                s_d.ovf_f = 1'b0;
            end
            s_d.arm_ovf = 1'b0;
        end
        for (int i = 0; i < 2; i++) begin
            if (cap_lo_acc[i]) begin
                if (s_q.arm_cap[i]) begin
                    s_d.cap_f[i] = 1'b0;
                end
                s_d.arm_cap[i]   = 1'b0;
                s_d.cap_block[i] = 1'b0;
            end
            if (cmp_lo_acc[i]) begin
                if (s_q.arm_cmp[i]) begin
                    s_d.cmp_f[i] = 1'b0;
                end
                s_d.arm_cmp[i] = 1'b0;
            end
        end
        if (ovf_ev) begin
            s_d.ovf_f = 1'b1;
        end
        s_d.cap_f = s_d.cap_f | cap_ev;
        s_d.cmp_f = s_d.cmp_f | cmp_ev;
    end

    // ****************************************************************
    // state register
    // ****************************************************************
    // reset restarts the counter from fffc and drops the pin latches
    always_ff @(posedge clk) begin
        if (reset) begin
            s_q          <= '0;
            s_q.ctl1     <= `CCT_CTL_RST;
            s_q.ctl2     <= `CCT_CTL_RST;
            s_q.cnt      <= `CCT_CNT_RST;
            s_q.cmp[0]   <= `CCT_CMP_RST;
            s_q.cmp[1]   <= `CCT_CMP_RST;
            s_q.pin      <= 2'b00;
            s_q.ext_s    <= 3'b000;
        end else begin
            s_q <= s_d;
        end
    end

endmodule : cct_timer
`default_nettype wire

// ===== dv/cct_pins_model.sv
// far side: capture inputs and external clock source
// assumes bench calls its tasks; pins idle low, clock still between bursts
`timescale 1ns/1ps
`default_nettype none
module cct_pins_model (
    input  wire logic       clk,
    output var  logic       ext_clock_pin,
    output var  logic [1:0] capture_pin
);
    // start idle
    initial begin
        ext_clock_pin = 1'b0;
        capture_pin = 2'b00;
    end
    // six falling cpu edges between active edges, margin over the minimum
    task automatic ext_burst(input int n);
        repeat (n) begin
            repeat (3) @(negedge clk);
            ext_clock_pin = 1'b1;
            repeat (3) @(negedge clk);
            ext_clock_pin = 1'b0;
        end
    endtask : ext_burst
    // pins are async to the timer, so change off the rising edge
    task automatic cap_set(input logic [1:0] v);
        @(negedge clk);
        capture_pin = v;
    endtask : cap_set
endmodule : cct_pins_model
`default_nettype wire

// ===== dv/cct_timer_assertions.sv
// port assertions for the capture/compare timer
// assumes binding onto cct_timer, one clock, sync reset
`timescale 1ns/1ps
`default_nettype none
// ****
// checker
// ****
module cct_timer_assertions
    import cct_pkg::*;
(
    input wire logic         clk,
    input wire logic         reset,
    input wire cct_axi_req_t axi_req,
    input wire cct_axi_rsp_t axi_rsp,
    input wire logic         cpu_irq_mask,
    input wire logic         halt,
    input wire logic         ext_clock_pin,
    input wire logic [1:0]   capture_pin,
    input wire logic [1:0]   compare_output_pin,
    input wire logic [1:0]   compare_output_pin_oe,
    input wire logic         timer_irq
);
    // one domain, so clock and reset are given once
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);
    sequence s_rd_taken;
        axi_req.arvalid && axi_rsp.arready;
    endsequence
    sequence s_wr_taken;
        axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready;
    endsequence
    a_read_answer: assert property (s_rd_taken |=> axi_rsp.rvalid)
        else $error("read not answered next cycle");
    a_write_answer: assert property (s_wr_taken |=> ##1 axi_rsp.bvalid)
        else $error("write not answered in two cycles");
    a_rdata_stands: assert property (axi_rsp.rvalid && !axi_req.rready
        |=> axi_rsp.rvalid && $stable(axi_rsp.rdata)) else $error("read data dropped");
    a_bresp_stands: assert property (axi_rsp.bvalid && !axi_req.bready
        |=> axi_rsp.bvalid && $stable(axi_rsp.bresp)) else $error("write answer dropped");
    a_bvalid_ends: assert property (axi_rsp.bvalid && axi_req.bready |=> !axi_rsp.bvalid)
        else $error("write answer repeated");
    a_read_busy: assert property (axi_rsp.rvalid |-> !axi_rsp.arready)
        else $error("read taken while answer pending");
    a_byte_only: assert property (axi_rsp.rvalid |-> axi_rsp.rdata[31:8] == 24'h0)
        else $error("upper read bits not zero");
    a_irq_masked: assert property (cpu_irq_mask |-> !timer_irq)
        else $error("request while cpu masked");
    a_pin_reset_low: assert property ($fell(reset) |-> compare_output_pin == 2'b00)
        else $error("compare pin not low out of reset");
endmodule : cct_timer_assertions

bind cct_timer cct_timer_assertions i_cct_timer_assertions (.clk, .reset, .axi_req,
    .axi_rsp, .cpu_irq_mask, .halt, .ext_clock_pin, .capture_pin, .compare_output_pin,
    .compare_output_pin_oe, .timer_irq);
`default_nettype wire

// ===== dv/test_capture_compare_timer16.sv
// register-level bench for the capture/compare timer
// assumes cct_timer, its checker bind and the pin model
`timescale 1ns/1ps
`default_nettype none
`include "cct_regs.svh"
module test_capture_compare_timer16
    import cct_pkg::*;
;
    logic         clk = 1'b0;
    logic         reset;
    cct_axi_req_t req;
    cct_axi_rsp_t rsp;
    logic         cpu_irq_mask;
    logic         halt;
    logic         ext_clock_pin;
    logic [1:0]   capture_pin;
    logic [1:0]   cmp_pin;
    logic [1:0]   cmp_oe;
    logic         timer_irq;
    logic [7:0]   rd;
    logic [7:0]   lat;
    logic [1:0]   rr;
    int           miscompares = 0;
    int           cmp_count = 0;
    int           cycles = 0;
    int           span;
    logic [7:0]   ofs [7] = '{8'h00, 8'h04, 8'h08, 8'h14, 8'h18, 8'h24, 8'h3c};
    logic [7:0]   rst [7] = '{8'h00, 8'h00, 8'h00, 8'h80, 8'h00, 8'h80, 8'h00};
    cct_timer i_cct_timer (.clk(clk), .reset(reset), .axi_req(req), .axi_rsp(rsp),
        .cpu_irq_mask(cpu_irq_mask), .halt(halt), .ext_clock_pin(ext_clock_pin),
        .capture_pin(capture_pin), .compare_output_pin(cmp_pin),
        .compare_output_pin_oe(cmp_oe), .timer_irq(timer_irq));
    cct_pins_model i_cct_pins_model (.clk(clk), .ext_clock_pin(ext_clock_pin),
        .capture_pin(capture_pin));
    // 50 mhz clock; ceiling well above the planned run
    always #10 clk = ~clk;
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            miscompares = miscompares + 1;
            conclude();
        end
    end
    // ****
    // tasks
    // ****
    task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
        cmp_count = cmp_count + 1;
        if (got !== exp) begin
            miscompares = miscompares + 1;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    // readies are sampled at the falling edge; nothing changes before the next rise
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic ta, tw, tb;
        @(posedge clk);
        req.awaddr <= a;
        req.wdata <= {24'h0, d};
        req.wstrb <= 4'hf;
        req.awvalid <= 1'b1;
        req.wvalid <= 1'b1;
        req.bready <= 1'b1;
        forever begin
            @(negedge clk);
            {ta, tw, tb} = {rsp.awready, rsp.wready, rsp.bvalid};
            @(posedge clk);
            if (ta) req.awvalid <= 1'b0;
            if (tw) req.wvalid <= 1'b0;
            if (tb) begin
                req.bready <= 1'b0;
                return;
            end
        end
    endtask : wr
    task automatic rdr(input logic [7:0] a);
        logic ta, tv;
        @(posedge clk);
        req.araddr <= a;
        req.arvalid <= 1'b1;
        req.rready <= 1'b1;
        forever begin
            @(negedge clk);
            {ta, tv} = {rsp.arready, rsp.rvalid};
            rd = rsp.rdata[7:0];
            rr = rsp.rresp;
            @(posedge clk);
            if (ta) req.arvalid <= 1'b0;
            if (tv) begin
                req.rready <= 1'b0;
                return;
            end
        end
    endtask : rdr
    task automatic conclude();
        if (miscompares == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : conclude
    // ****
    // tests
    // ****
    initial begin
        req = '0;
        reset = 1'b1;
        cpu_irq_mask = 1'b0;
        halt = 1'b1;
        repeat (20) @(posedge clk);
        reset <= 1'b0;
        foreach (ofs[k]) begin
            rdr(ofs[k]);
            chk("reset value", rd, rst[k]);
            chk("read response", rr, k == 6 ? 2'b10 : 2'b00);
        end
        // counter runs, halts, then is reloaded through either low byte
        foreach (ofs[k]) if (k < 2) begin
            halt <= 1'b0;
            repeat (30) @(posedge clk);
            halt <= 1'b1;
            wr(k ? `CCT_OFS_SCNTL : `CCT_OFS_CNTL, 8'h55);
            rdr(`CCT_OFS_CNTH);
            chk("count high", rd, 8'hff);
            rdr(`CCT_OFS_CNTL);
            chk("count low", rd, 8'hfc);
        end
        // overflow left pending by the runs above
        wr(`CCT_OFS_CTL1, 8'h20);
        chk("overflow irq", timer_irq, 1'b1);
        cpu_irq_mask <= 1'b1;
        @(negedge clk);
        chk("masked irq", timer_irq, 1'b0);
        @(posedge clk);
        cpu_irq_mask <= 1'b0;
        rdr(`CCT_OFS_CNTL);
        rdr(`CCT_OFS_STAT);
        chk("overflow kept", rd & 8'h10, 8'h10);
        rdr(`CCT_OFS_SCNTL);
        rdr(`CCT_OFS_STAT);
        chk("shadow no clear", rd & 8'h10, 8'h10);
        rdr(`CCT_OFS_CNTL);
        rdr(`CCT_OFS_STAT);
        chk("overflow clear", rd & 8'h10, 8'h00);
        // latch stays while the counter runs on
        halt <= 1'b0;
        rdr(`CCT_OFS_CNTH);
        repeat (40) @(posedge clk);
        rdr(`CCT_OFS_CNTH);
        rdr(`CCT_OFS_CNTL);
        lat = rd;
        halt <= 1'b1;
        rdr(`CCT_OFS_CNTL);
        span = 32'(8'(rd - lat));
        chk("latch frozen", 16'(span > 20 && span < 40), 16'h1);
        lat = rd;
        rdr(`CCT_OFS_SCNTL);
        chk("live low", rd, lat);
        // capture at a frozen count; second capture blocked by high read
        wr(`CCT_OFS_CTL1, 8'h84);
        wr(`CCT_OFS_CNTL, 8'h00);
        i_cct_pins_model.cap_set(2'b11);
        repeat (4) @(posedge clk);
        rdr(`CCT_OFS_STAT);
        chk("capture flag", rd & 8'h03, 8'h01);
        chk("capture irq", timer_irq, 1'b1);
        rdr(`CCT_OFS_CAP1H);
        chk("capture high", rd, 8'hff);
        rdr(`CCT_OFS_CAP1L);
        chk("capture low", rd, 8'hfc);
        rdr(`CCT_OFS_STAT);
        chk("capture clear", rd & 8'h03, 8'h00);
        rdr(`CCT_OFS_CAP1H);
        i_cct_pins_model.cap_set(2'b00);
        i_cct_pins_model.cap_set(2'b01);
        repeat (5) @(posedge clk);
        rdr(`CCT_OFS_STAT);
        chk("capture blocked", rd & 8'h03, 8'h02);
        rdr(`CCT_OFS_CAP1L);
        chk("shared irq", timer_irq, 1'b1);
        // force, then match on channel one while channel two is suspended
        wr(`CCT_OFS_CTL2, 8'h01);
        wr(`CCT_OFS_CTL1, 8'h09);
        chk("forced pin", {cmp_oe[0], cmp_pin[0]}, 2'b11);
        rdr(`CCT_OFS_STAT);
        chk("force no flag", rd & 8'h0c, 8'h00);
        wr(`CCT_OFS_CTL2, 8'h41);
        wr(`CCT_OFS_CTL1, 8'h08);
        chk("force ignored", cmp_pin[0], 1'b1);
        wr(`CCT_OFS_CTL2, 8'h01);
        wr(`CCT_OFS_CMP1H, 8'h00);
        wr(`CCT_OFS_CMP1L, 8'h10);
        wr(`CCT_OFS_CMP2H, 8'h00);
        wr(`CCT_OFS_CTL1, 8'h40);
        wr(`CCT_OFS_CNTL, 8'h00);
        halt <= 1'b0;
        repeat (60) @(posedge clk);
        halt <= 1'b1;
        chk("match pin", cmp_pin[0], 1'b0);
        rdr(`CCT_OFS_STAT);
        chk("match flags", rd & 8'h0c, 8'h04);
        chk("compare irq", timer_irq, 1'b1);
        rdr(`CCT_OFS_CMP1L);
        rdr(`CCT_OFS_STAT);
        chk("compare clear", rd & 8'h0c, 8'h00);
        // prescaler: counts over 160 cpu clocks for each divider
        foreach (ofs[k]) if (k < 3) begin
            wr(`CCT_OFS_CTL2, {4'h0, 2'(k), 2'b00});
            wr(`CCT_OFS_CNTL, 8'h00);
            halt <= 1'b0;
            repeat (160) @(posedge clk);
            halt <= 1'b1;
            rdr(`CCT_OFS_CNTL);
            span = 32'(8'(rd - 8'hfc)) - (80 >> k);
            chk("prescale", 16'(span > -3 && span < 3), 16'h1);
        end
        // external clock, rising edges counted
        wr(`CCT_OFS_CTL2, 8'h1c);
        halt <= 1'b0;
        wr(`CCT_OFS_CNTL, 8'h00);
        i_cct_pins_model.ext_burst(6);
        repeat (6) @(posedge clk);
        rdr(`CCT_OFS_CNTH);
        chk("ext high", rd, 8'h00);
        rdr(`CCT_OFS_CNTL);
        chk("ext low", rd, 8'h02);
        conclude();
    end
endmodule : test_capture_compare_timer16
`default_nettype wire
